/* File: hw/uart_pkg.sv */
//==============================================================
// Register map, field positions and timing constants for the UART
// control block. Shared by the top module and its bench.
package uart_pkg;
	// Register byte addresses on APB
	localparam logic [7:0] ADDR_MODE = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h04;
	localparam logic [7:0] ADDR_TXDATA = 8'h08;
	localparam logic [7:0] ADDR_RXDATA = 8'h0c;
	localparam logic [7:0] ADDR_BAUD = 8'h10;
	// Mode register fields
	localparam int MD_ON = 15;
	localparam int MD_INFRARED_ENCODE_ENABLE = 12;
	localparam int MD_AUTO_RATE_MEASURE = 5;
	localparam int MD_RX_IDLE_POLARITY = 4;
	localparam int MD_FAST_OVERSAMPLE_SELECT = 3;
	localparam int MD_FMT = 1;
	localparam int MD_STOP = 0;
	localparam logic [15:0] MODE_WMASK = 16'h903f;
	// Status and control register fields
	localparam int ST_ADM = 24;
	localparam int ST_ADDR = 16;
	localparam int ST_TXISEL = 14;
	localparam int ST_TXINV = 13;
	localparam int ST_RXEN = 12;
	localparam int ST_BRK = 11;
	localparam int ST_TXEN = 10;
	localparam int ST_TXBF = 9;
	localparam int ST_TX_ALL_EMPTY = 8;
	localparam int ST_RXISEL = 6;
	localparam int ST_ADDRESS_CHAR_ENABLE = 5;
	localparam int ST_RECEIVER_IDLE = 4;
	localparam int ST_PARITY_ERROR = 3;
	localparam int ST_FRAMING_ERROR = 2;
	localparam int ST_OVERRUN_ERROR = 1;
	localparam int ST_RXDA = 0;
	localparam logic [31:0] STAT_WMASK = 32'h01ff_fce2;
	// Character formats and transmit interrupt modes
	localparam logic [1:0] FMT_9N = 2'h3;
	localparam logic [1:0] FMT_8O = 2'h2;
	localparam logic [1:0] FMT_8E = 2'h1;
	localparam logic [1:0] FMT_8N = 2'h0;
	localparam logic [1:0] TXI_SPACE = 2'h0;
	localparam logic [1:0] TXI_DONE = 2'h1;
	localparam logic [1:0] TXI_EMPTY = 2'h2;
	// Oversampling and frame timing
	localparam logic [4:0] OS_STD = 5'h10;
	localparam logic [4:0] OS_FAST = 5'h04;
	localparam int OS_STD_LOG2 = 4;
	localparam int OS_FAST_LOG2 = 2;
	localparam int FRAME_W = 14;
	localparam logic [3:0] BREAK_BITS = 4'he;
	localparam logic [3:0] LEN_8N = 4'h9;
	localparam logic [3:0] LEN_EXT = 4'ha;
	localparam logic [7:0] SYNC_CHAR = 8'h55;
	localparam int SYNC_LOG2 = 3;
	localparam logic [2:0] SYNC_FALLS = 3'h4;
	localparam logic [31:0] BAUD_RESET = 32'h0000_0000;
endpackage : uart_pkg

/* File: hw/uart_tx_store.sv */
//==============================================================
// Small transmit character store with registered read data.
// Assumes the caller keeps pointers and counts; no reset needed.
`timescale 1ns/10ps

module uart_tx_store #(
	parameter int WIDTH = 9, // Character width
	parameter int DEPTH = 4 // Characters held
) (
	input wire logic clk_sys, // System clock
	input wire logic wr_en, // Write strobe
	input wire logic [$clog2(DEPTH)-1:0] wr_addr, // Write slot
	input wire logic [WIDTH-1:0] wr_data, // Write character
	input wire logic [$clog2(DEPTH)-1:0] rd_addr, // Read slot
	output logic [WIDTH-1:0] rd_data // Registered read data
);
	logic [WIDTH-1:0] mem [DEPTH];

	//==============================================================
	// Storage
	// Read data lags the address by one edge
	always_ff @(posedge clk_sys) begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
		rd_data <= mem[rd_addr];
	end
endmodule : uart_tx_store

/* File: hw/uart_mode_status_control.sv */
//==============================================================
// UART framing, rate, polarity, transmit buffer and status, on APB.
// Assumes a single clock and serial_in_pin already synchronous.
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/10ps

// Contract
// - Format field picks 9N, 8 odd, 8 even or 8N characters.
// - Stop select set sends two stop bits, clear sends one.
// - Auto-rate measures the next 0x55 sync and then self-clears.
// - Receive polarity set makes the idle receive level 0.
// - Fast select uses a 4x baud clock, otherwise 16x.
// - With auto match on, address chars matching the match char gate reception.
// - Transmit irq mode picks empty, all sent or space free.
// - Transmit polarity sets idle level, inverted sense with IR.
// - Receiver works only when enabled and on, else pin ignored.
// - Break sends start, twelve zeros, stop, then self-clears.
// - Transmit enable drives the pin; clearing aborts and flushes.
// - Buffer full flag is 1 only when no character fits.
// - All-empty flag is 1 only with shifter and buffer empty.
module uart_mode_status_control #(
	parameter int TX_DEPTH = 4, // Transmit buffer characters
	parameter int BAUD_W = 16 // Baud divisor width
) (
	input wire logic clk_sys, // 100 MHz clock
	input wire logic reset, // Sync reset, high
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB write
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // Unmapped address
	input wire logic serial_in_pin, // Serial receive line
	output logic serial_out_pin, // Serial transmit line
	output logic serial_out_oe_n, // Low while driving
	output logic tx_irq_request // Transmit irq level
);
	localparam int AW = $clog2(TX_DEPTH);
	localparam int MW = BAUD_W + 8;
	typedef enum logic [2:0] {TX_IDLE = 3'h1, TX_LOAD = 3'h2,
		TX_SHIFT = 3'h4} tx_state_e;
	typedef enum logic [4:0] {RX_IDLE = 5'h01, RX_START = 5'h02,
		RX_DATA = 5'h04, RX_MEASURE = 5'h08, RX_SKIP = 5'h10} rx_state_e;

	if (TX_DEPTH < 2 || (1 << AW) != TX_DEPTH) begin : g_bad_depth
		$error("TX_DEPTH must be a power of two, at least 2");
	end
	if (BAUD_W < 8 || BAUD_W > 24) begin : g_bad_baud
		$error("BAUD_W must lie between 8 and 24");
	end

	function automatic logic [4:0] os_ticks(input logic fast);
		os_ticks = fast ? uart_pkg::OS_FAST : uart_pkg::OS_STD;
	endfunction : os_ticks

	function automatic logic par_bit(input logic [1:0] f,
		input logic [7:0] d);
		par_bit = (f == uart_pkg::FMT_8O) ? ~^d : ^d;
	endfunction : par_bit

	logic [15:0] mode_reg, mode_next;
	logic [31:0] stat_reg, stat_next, rd_v;
	logic [BAUD_W-1:0] baud_reg, baud_next, div_reg, div_next, auto_rate_measure_val;
	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next, pslverr_reg, pslverr_next, err_v;
	tx_state_e tx_state_reg, tx_state_next;
	logic [uart_pkg::FRAME_W-1:0] tx_frame_reg, tx_frame_next;
	logic [3:0] tx_bits_reg, tx_bits_next;
	logic [4:0] tx_os_reg, tx_os_next, rx_os_reg, rx_os_next, os_n;
	logic [AW-1:0] head_reg, head_next, tail_reg, tail_next;
	logic [AW:0] tx_count_reg, tx_count_next;
	logic tx_brk_reg, tx_brk_next, out_reg, out_next, oe_n_reg, oe_n_next;
	logic irq_reg, irq_next, push, pop, brk_done, bit_v;
	logic [8:0] tx_rd_data;
	rx_state_e rx_state_reg, rx_state_next;
	logic [9:0] rx_sh_reg, rx_sh_next;
	logic [3:0] rx_idx_reg, rx_idx_next, rx_len;
	logic [8:0] rx_char_reg, rx_char_next, ch_v;
	logic rx_parity_error_reg, rx_parity_error_next, rx_framing_error_reg, rx_framing_error_next;
	logic rx_avail_reg, rx_avail_next, open_reg, open_next;
	logic rx_prev_reg, accept_v, is_addr_v, auto_rate_measure_done, overrun_error_set;
	logic [MW-1:0] meas_reg, meas_next, meas_q;
	logic [2:0] falls_reg, falls_next;
	logic module_on, infrared_encode_enable, auto_rate_measure;
	logic rx_idle_polarity, fast_oversample_select, stop_count_select;
	logic [1:0] char_format_select, tx_irq_mode;
	logic auto_match_enable, tx_idle_polarity, receiver_enable;
	logic send_break, transmitter_enable, address_char_enable;
	logic [7:0] match_char;
	logic tick, tx_on, rx_on, rx_n, fall, tx_full, tx_all_empty;
	logic apb_fire, wr_fire, wr_mode, wr_stat, wr_baud, wr_tx, rd_rx;

	//==============================================================
	// Field decode
	assign module_on = mode_reg[uart_pkg::MD_ON];
	assign infrared_encode_enable = mode_reg[uart_pkg::MD_INFRARED_ENCODE_ENABLE];
	assign auto_rate_measure = mode_reg[uart_pkg::MD_AUTO_RATE_MEASURE];
	assign rx_idle_polarity = mode_reg[uart_pkg::MD_RX_IDLE_POLARITY];
	assign fast_oversample_select = mode_reg[uart_pkg::MD_FAST_OVERSAMPLE_SELECT];
	assign char_format_select = mode_reg[uart_pkg::MD_FMT +: 2];
	assign stop_count_select = mode_reg[uart_pkg::MD_STOP];
	assign auto_match_enable = stat_reg[uart_pkg::ST_ADM];
	assign match_char = stat_reg[uart_pkg::ST_ADDR +: 8];
	assign tx_irq_mode = stat_reg[uart_pkg::ST_TXISEL +: 2];
	assign tx_idle_polarity = stat_reg[uart_pkg::ST_TXINV];
	assign receiver_enable = stat_reg[uart_pkg::ST_RXEN];
	assign send_break = stat_reg[uart_pkg::ST_BRK];
	assign transmitter_enable = stat_reg[uart_pkg::ST_TXEN];
	assign address_char_enable = stat_reg[uart_pkg::ST_ADDRESS_CHAR_ENABLE];
	assign os_n = os_ticks(fast_oversample_select);
	assign tick = module_on && div_reg == baud_reg;
	assign tx_on = module_on && transmitter_enable;
	assign rx_on = module_on && receiver_enable;
	// normalise so idle reads as 1
	assign rx_n = serial_in_pin ^ rx_idle_polarity;
	assign fall = rx_prev_reg && !rx_n;
	// full when no slot is free
	assign tx_full = tx_count_reg == (AW + 1)'(TX_DEPTH);
	assign tx_all_empty = tx_count_reg == '0 && tx_state_reg == TX_IDLE;
	assign apb_fire = psel && penable && pready_reg;
	assign wr_fire = apb_fire && pwrite;
	assign wr_mode = wr_fire && paddr == uart_pkg::ADDR_MODE;
	assign wr_stat = wr_fire && paddr == uart_pkg::ADDR_STAT;
	assign wr_baud = wr_fire && paddr == uart_pkg::ADDR_BAUD;
	assign wr_tx = wr_fire && paddr == uart_pkg::ADDR_TXDATA;
	// Clear with the read data capture so no new char slips in between
	assign rd_rx = psel && penable && !pready_reg && !pwrite &&
		paddr == uart_pkg::ADDR_RXDATA;
	assign push = wr_tx && tx_on && !tx_full;
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign serial_out_pin = out_reg;
	assign serial_out_oe_n = oe_n_reg;
	assign tx_irq_request = irq_reg;

	uart_tx_store #(.WIDTH(9), .DEPTH(TX_DEPTH)) u_store (
		.clk_sys(clk_sys),
		.wr_en(push),
		.wr_addr(tail_reg),
		.wr_data(pwdata[8:0]),
		.rd_addr(head_reg),
		.rd_data(tx_rd_data)
	);

	//==============================================================
	// Registers and APB slave; answer one cycle into access phase
	always_comb begin
		mode_next = mode_reg;
		stat_next = stat_reg;
		baud_next = baud_reg;
		div_next = (tick || !module_on) ? '0 : div_reg + 1'b1;
		if (wr_mode)
			mode_next = pwdata[15:0] & uart_pkg::MODE_WMASK;
		if (wr_stat) begin
			stat_next = pwdata & uart_pkg::STAT_WMASK;
			stat_next[uart_pkg::ST_OVERRUN_ERROR] = stat_reg[uart_pkg::ST_OVERRUN_ERROR] &
				pwdata[uart_pkg::ST_OVERRUN_ERROR];
		end
		if (wr_baud)
			baud_next = pwdata[BAUD_W-1:0];
		// hardware clear, a new software set wins
		if (auto_rate_measure_done) begin
			baud_next = auto_rate_measure_val;
			if (!(wr_mode && pwdata[uart_pkg::MD_AUTO_RATE_MEASURE]))
				mode_next[uart_pkg::MD_AUTO_RATE_MEASURE] = 1'b0;
		end
		if (brk_done && !(wr_stat && pwdata[uart_pkg::ST_BRK]))
			stat_next[uart_pkg::ST_BRK] = 1'b0;
		if (overrun_error_set)
			stat_next[uart_pkg::ST_OVERRUN_ERROR] = 1'b1;
		rd_v = '0;
		err_v = 1'b0;
		case (paddr)
			uart_pkg::ADDR_MODE: rd_v = {16'h0000, mode_reg};
			uart_pkg::ADDR_STAT: begin
				rd_v = stat_reg;
				rd_v[uart_pkg::ST_TXBF] = tx_full;
				rd_v[uart_pkg::ST_TX_ALL_EMPTY] = tx_all_empty;
				rd_v[uart_pkg::ST_RECEIVER_IDLE] = rx_state_reg == RX_IDLE;
				rd_v[uart_pkg::ST_PARITY_ERROR] = rx_parity_error_reg;
				rd_v[uart_pkg::ST_FRAMING_ERROR] = rx_framing_error_reg;
				rd_v[uart_pkg::ST_RXDA] = rx_avail_reg;
			end
			uart_pkg::ADDR_TXDATA: rd_v = '0;
			uart_pkg::ADDR_RXDATA: rd_v = {23'h000000, rx_char_reg};
			uart_pkg::ADDR_BAUD: rd_v = 32'(baud_reg);
			default: err_v = 1'b1;
		endcase
		pready_next = psel && penable && !pready_reg;
		prdata_next = pready_next ? rd_v : prdata_reg;
		pslverr_next = pready_next ? err_v : pslverr_reg;
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			mode_reg <= '0;
			stat_reg <= '0;
			baud_reg <= uart_pkg::BAUD_RESET[BAUD_W-1:0];
			div_reg <= '0;
			prdata_reg <= '0;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			mode_reg <= mode_next;
			stat_reg <= stat_next;
			baud_reg <= baud_next;
			div_reg <= div_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	//==============================================================
	// Transmitter: whole frame is built up front, then shifted
	always_comb begin
		tx_state_next = tx_state_reg;
		tx_frame_next = tx_frame_reg;
		tx_bits_next = tx_bits_reg;
		tx_os_next = tx_os_reg;
		tx_brk_next = tx_brk_reg;
		head_next = head_reg;
		tail_next = push ? tail_reg + 1'b1 : tail_reg;
		pop = 1'b0;
		brk_done = 1'b0;
		unique case (tx_state_reg)
			TX_IDLE: begin
				tx_os_next = '0;
				if (tx_on && send_break) begin
					tx_frame_next = '0;
					tx_frame_next[uart_pkg::FRAME_W-1] = 1'b1;
					tx_bits_next = uart_pkg::BREAK_BITS;
					tx_brk_next = 1'b1;
					tx_state_next = TX_SHIFT;
				end else if (tx_on && tx_count_reg != '0) begin
					tx_state_next = TX_LOAD;
				end
			end
			// Extra cycle lets the store's read data settle
			TX_LOAD: begin
				pop = 1'b1;
				head_next = head_reg + 1'b1;
				tx_brk_next = 1'b0;
				tx_frame_next = '1;
				tx_frame_next[0] = 1'b0;
				tx_frame_next[8:1] = tx_rd_data[7:0];
				// ninth bit, parity bit or stop
				// stop bits come from the ones fill
				// Count covers the first stop too, so frames never abut
				if (char_format_select == uart_pkg::FMT_8N) begin
					tx_bits_next = uart_pkg::LEN_8N +
						{3'h0, stop_count_select} + 1'b1;
				end else begin
					tx_frame_next[9] = (char_format_select ==
						uart_pkg::FMT_9N) ? tx_rd_data[8] :
						par_bit(char_format_select, tx_rd_data[7:0]);
					tx_bits_next = uart_pkg::LEN_EXT +
						{3'h0, stop_count_select} + 1'b1;
				end
				tx_state_next = TX_SHIFT;
			end
			TX_SHIFT: begin
				if (tick && tx_os_reg == os_n - 1'b1) begin
					tx_os_next = '0;
					tx_frame_next = {1'b1, tx_frame_reg[uart_pkg::FRAME_W-1:1]};
					tx_bits_next = tx_bits_reg - 1'b1;
					if (tx_bits_reg == 4'h1) begin
						tx_state_next = TX_IDLE;
						brk_done = tx_brk_reg;
					end
				end else if (tick) begin
					tx_os_next = tx_os_reg + 1'b1;
				end
			end
			default: tx_state_next = TX_IDLE;
		endcase
		tx_count_next = tx_count_reg + {{AW{1'b0}}, push} -
			{{AW{1'b0}}, pop};
		// disable aborts the frame and empties the buffer
		if (!tx_on) begin
			tx_state_next = TX_IDLE;
			head_next = '0;
			tail_next = '0;
			tx_count_next = '0;
		end
		// idle level, IR pulses in the first quarter bit
		bit_v = (tx_state_reg == TX_SHIFT) ? tx_frame_reg[0] : 1'b1;
		if (infrared_encode_enable)
			out_next = tx_idle_polarity ^
				(!bit_v && tx_os_reg < (os_n >> 2));
		else
			out_next = bit_v ^ tx_idle_polarity;
		oe_n_next = !tx_on;
		// irq level by mode; reserved code stays low
		unique case (tx_irq_mode)
			uart_pkg::TXI_EMPTY: irq_next = tx_count_next == '0;
			uart_pkg::TXI_DONE: irq_next = tx_count_next == '0 &&
				tx_state_next == TX_IDLE;
			uart_pkg::TXI_SPACE: irq_next = tx_count_next !=
				(AW + 1)'(TX_DEPTH);
			default: irq_next = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			tx_state_reg <= TX_IDLE;
			tx_frame_reg <= '1;
			tx_bits_reg <= '0;
			tx_os_reg <= '0;
			tx_brk_reg <= 1'b0;
			head_reg <= '0;
			tail_reg <= '0;
			tx_count_reg <= '0;
			out_reg <= 1'b1;
			oe_n_reg <= 1'b1;
			irq_reg <= 1'b0;
		end else begin
			tx_state_reg <= tx_state_next;
			tx_frame_reg <= tx_frame_next;
			tx_bits_reg <= tx_bits_next;
			tx_os_reg <= tx_os_next;
			tx_brk_reg <= tx_brk_next;
			head_reg <= head_next;
			tail_reg <= tail_next;
			tx_count_reg <= tx_count_next;
			out_reg <= out_next;
			oe_n_reg <= oe_n_next;
			irq_reg <= irq_next;
		end
	end

	//==============================================================
	// Receiver and sync-character rate measurement
	always_comb begin
		rx_state_next = rx_state_reg;
		rx_os_next = rx_os_reg;
		rx_sh_next = rx_sh_reg;
		rx_idx_next = rx_idx_reg;
		rx_char_next = rx_char_reg;
		rx_parity_error_next = rx_parity_error_reg;
		rx_framing_error_next = rx_framing_error_reg;
		rx_avail_next = rx_avail_reg && !rd_rx;
		open_next = open_reg;
		meas_next = meas_reg + 1'b1;
		falls_next = falls_reg;
		auto_rate_measure_done = 1'b0;
		overrun_error_set = 1'b0;
		rx_len = (char_format_select == uart_pkg::FMT_8N) ?
			uart_pkg::LEN_8N - 1'b1 : uart_pkg::LEN_EXT - 1'b1;
		ch_v = '0;
		is_addr_v = 1'b0;
		accept_v = 1'b0;
		// Bit time is one eighth of the span of eight sync character bits
		meas_q = fast_oversample_select ?
			meas_reg >> (uart_pkg::SYNC_LOG2 + uart_pkg::OS_FAST_LOG2) :
			meas_reg >> (uart_pkg::SYNC_LOG2 + uart_pkg::OS_STD_LOG2);
		auto_rate_measure_val = (meas_q == '0) ? '0 : BAUD_W'(meas_q - 1'b1);
		unique case (rx_state_reg)
			// start is a departure from the idle level
			RX_IDLE: begin
				rx_os_next = '0;
				rx_idx_next = '0;
				// Count the cycle of the first fall as well
				meas_next = MW'(1);
				falls_next = '0;
				if (fall && auto_rate_measure)
					rx_state_next = RX_MEASURE;
				else if (fall)
					rx_state_next = RX_START;
			end
			RX_START: if (tick) begin
				rx_os_next = rx_os_reg + 1'b1;
				if (rx_os_reg == (os_n >> 1) - 1'b1) begin
					rx_os_next = '0;
					rx_state_next = rx_n ? RX_IDLE : RX_DATA;
				end
			end
			RX_DATA: if (tick) begin
				rx_os_next = rx_os_reg + 1'b1;
				if (rx_os_reg == os_n - 1'b1) begin
					rx_os_next = '0;
					rx_sh_next[rx_idx_reg] = rx_n;
					rx_idx_next = rx_idx_reg + 1'b1;
					if (rx_idx_reg == rx_len) begin
						rx_state_next = RX_IDLE;
						ch_v = (char_format_select == uart_pkg::FMT_9N) ?
							rx_sh_next[8:0] : {1'b0, rx_sh_next[7:0]};
						// address chars open or close the gate
						is_addr_v = char_format_select == uart_pkg::FMT_9N &&
							address_char_enable && ch_v[8];
						if (auto_match_enable && is_addr_v)
							open_next = ch_v[7:0] == match_char;
						accept_v = !auto_match_enable || open_next;
						// hold one char; a second is overrun
						if (accept_v && rx_avail_reg && !rd_rx) begin
							overrun_error_set = 1'b1;
						end else if (accept_v) begin
							rx_avail_next = 1'b1;
							rx_char_next = ch_v;
							rx_framing_error_next = !rx_n;
							rx_parity_error_next = (char_format_select ==
								uart_pkg::FMT_8O || char_format_select ==
								uart_pkg::FMT_8E) && rx_sh_next[8] !=
								par_bit(char_format_select, rx_sh_next[7:0]);
						end
					end
				end
			end
			// count clocks over four more falling edges
			RX_MEASURE: if (fall) begin
				falls_next = falls_reg + 1'b1;
				if (falls_reg == uart_pkg::SYNC_FALLS - 1'b1) begin
					auto_rate_measure_done = 1'b1;
					rx_state_next = RX_SKIP;
				end
			end
			RX_SKIP: if (rx_n) rx_state_next = RX_IDLE;
			default: rx_state_next = RX_IDLE;
		endcase
		if (!rx_on)
			rx_state_next = RX_IDLE;
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rx_state_reg <= RX_IDLE;
			rx_os_reg <= '0;
			rx_sh_reg <= '0;
			rx_idx_reg <= '0;
			rx_char_reg <= '0;
			rx_parity_error_reg <= 1'b0;
			rx_framing_error_reg <= 1'b0;
			rx_avail_reg <= 1'b0;
			open_reg <= 1'b0;
			meas_reg <= '0;
			falls_reg <= '0;
			rx_prev_reg <= 1'b1;
		end else begin
			rx_state_reg <= rx_state_next;
			rx_os_reg <= rx_os_next;
			rx_sh_reg <= rx_sh_next;
			rx_idx_reg <= rx_idx_next;
			rx_char_reg <= rx_char_next;
			rx_parity_error_reg <= rx_parity_error_next;
			rx_framing_error_reg <= rx_framing_error_next;
			rx_avail_reg <= rx_avail_next;
			open_reg <= open_next;
			meas_reg <= meas_next;
			falls_reg <= falls_next;
			rx_prev_reg <= rx_n;
		end
	end

	//==============================================================
	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	a_txen_flush: assert property (!tx_on |=> tx_count_reg == '0 &&
		tx_state_reg == TX_IDLE) else $error("buffer kept while disabled");
	a_tx_all_empty_busy: assert property (tx_state_reg != TX_IDLE |->
		!tx_all_empty) else $error("all-empty set while sending");
	a_full_block: assert property (tx_full && wr_tx && !pop
		&& tx_on |=> tx_count_reg == (AW + 1)'(TX_DEPTH))
		else $error("full overrun");
	a_two_stops: assert property (tx_state_reg == TX_LOAD &&
		stop_count_select |=> tx_bits_reg ==
		(($past(char_format_select) == uart_pkg::FMT_8N) ? 4'hb : 4'hc))
		else $error("stop count wrong");
	a_break_frame: assert property (tx_state_reg == TX_IDLE &&
		tx_on && send_break |=> tx_bits_reg == 4'he &&
		tx_frame_reg[12:0] == 13'h0000) else $error("break frame wrong");
	a_rx_ignored: assert property (!rx_on |=>
		rx_state_reg == RX_IDLE) else $error("receiver ran disabled");
	a_auto_rate_measure_clear: assert property ($fell(auto_rate_measure) &&
		!$past(wr_mode) |-> $past(rx_state_reg) == RX_MEASURE)
		else $error("auto-rate cleared without measurement");
	a_irq_empty: assert property (tx_irq_mode == uart_pkg::TXI_EMPTY &&
		tx_count_reg == '0 && !push ##1 tx_irq_mode == uart_pkg::TXI_EMPTY
		|-> irq_reg) else $error("empty irq missing");
	a_start_mid: assert property (rx_state_reg == RX_START && rx_on
		&& !fast_oversample_select && rx_os_reg == 5'h07 && tick
		|=> rx_state_reg != RX_START) else $error("start not checked mid");
endmodule : uart_mode_status_control

/* File: sim/uart_remote.sv */
// Remote serial party that drives the block's receive line.
// Assumes the bench clock and a bit time given in clocks.
`timescale 1ns/10ps

//==========
// Remote device
module uart_remote (
	input wire logic clk_sys, // Bench clock
	output logic line_out // To receive pin
);
	initial line_out = 1'b1;

	// whole frame, start bit first, LSB first
	task send(input logic [7:0] d, input int p);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_sys);
			line_out <= f[i];
			repeat (p - 1) @(posedge clk_sys);
		end
	endtask : send
endmodule : uart_remote

/* File: sim/tb_top.sv */
// Register-level bench for the UART control block.
// Assumes APB answers with pready and a baud divisor of zero.
`timescale 1ns/10ps

//==========
// Bench top
module tb_top;
	logic clk_sys, reset, psel, penable, pwrite, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, serial_in_pin, serial_out_pin;
	logic serial_out_oe_n, tx_irq_request;
	logic [13:0] frm;
	int n_mismatch = 0;
	int checks = 0;

	uart_mode_status_control u_uart_mode_status_control (.clk_sys,
		.reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .serial_in_pin, .serial_out_pin,
		.serial_out_oe_n, .tx_irq_request);
	uart_remote u_uart_remote (.clk_sys, .line_out(serial_in_pin));

	// Free-running 100 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	// One APB transfer; held until pready is seen
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Send one char and sample n bits mid-bit off the line
	task txf(input logic [15:0] m, input logic [7:0] d, input int n,
		input logic [13:0] e);
		int p;
		p = m[uart_pkg::MD_FAST_OVERSAMPLE_SELECT] ? 4 : 16;
		frm = 14'h0;
		apb(1'b1, uart_pkg::ADDR_MODE, {16'h0, m});
		apb(1'b1, uart_pkg::ADDR_TXDATA, {24'h0, d});
		do @(posedge clk_sys); while (serial_out_pin !== 1'b0);
		repeat (p / 2) @(posedge clk_sys);
		for (int i = 0; i < n; i++) begin
			frm[i] = serial_out_pin;
			repeat (p) @(posedge clk_sys);
		end
		chk("tx frame", {18'h0, e}, {18'h0, frm});
	endtask : txf

	task end_sim;
		if (n_mismatch == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_sim

	// Hang guard, well past the longest expected run
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_mismatch++;
		end_sim;
	end

	//==========
	// Main sequence
	initial begin
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (12) @(posedge clk_sys);
		reset <= 1'b0;
		apb(1'b0, uart_pkg::ADDR_STAT, 32'h0);
		chk("status rst", 32'h110, rd);
		apb(1'b0, 8'h14, 32'h0);
		chk("unmapped", 32'h1, {31'h0, err});
		apb(1'b1, uart_pkg::ADDR_BAUD, 32'h0);
		apb(1'b1, uart_pkg::ADDR_STAT, 32'h1400);
		txf(16'h8000, 8'ha5, 10, 14'h34a);
		chk("oe_n on", 32'h0, {31'h0, serial_out_oe_n});
		txf(16'h800d, 8'h3c, 12, 14'he78);
		apb(1'b1, uart_pkg::ADDR_STAT, 32'h1c00);
		txf(16'h8000, 8'h00, 14, 14'h2000);
		apb(1'b0, uart_pkg::ADDR_STAT, 32'h0);
		chk("brk clear", 32'h0, {31'h0, rd[11]});
		// Drain the char that followed the break
		do apb(1'b0, uart_pkg::ADDR_STAT, 32'h0); while (rd[8] !== 1'b1);
		u_uart_remote.send(8'h5a, 16);
		apb(1'b0, uart_pkg::ADDR_RXDATA, 32'h0);
		chk("rx data", 32'h5a, rd);
		apb(1'b0, uart_pkg::ADDR_STAT, 32'h0);
		chk("idle stat", 32'h1510, rd);
		chk("irq space", 32'h1, {31'h0, tx_irq_request});
		repeat (6) apb(1'b1, uart_pkg::ADDR_TXDATA, 32'h0ff);
		apb(1'b0, uart_pkg::ADDR_STAT, 32'h0);
		chk("full stat", 32'h1610, rd);
		chk("irq full", 32'h0, {31'h0, tx_irq_request});
		// Dropping the enable must flush the queue
		apb(1'b1, uart_pkg::ADDR_STAT, 32'hb000);
		apb(1'b0, uart_pkg::ADDR_STAT, 32'h0);
		chk("flush stat", 32'hb110, rd);
		chk("oe_n off", 32'h1, {31'h0, serial_out_oe_n});
		chk("irq empty", 32'h1, {31'h0, tx_irq_request});
		chk("tx idle inv", 32'h0, {31'h0, serial_out_pin});
		// Sync char at twice the bit time gives a divisor of one
		apb(1'b1, uart_pkg::ADDR_MODE, 32'h9020);
		u_uart_remote.send(8'h55, 32);
		apb(1'b0, uart_pkg::ADDR_BAUD, 32'h0);
		chk("auto baud", 32'h1, rd);
		apb(1'b0, uart_pkg::ADDR_MODE, 32'h0);
		chk("auto clear", 32'h9000, rd);
		chk("ir idle", 32'h1, {31'h0, serial_out_pin});
		// Inverted idle turns the high line into a start of zeros
		apb(1'b1, uart_pkg::ADDR_MODE, 32'h9010);
		apb(1'b0, uart_pkg::ADDR_STAT, 32'h0);
		chk("rx busy", 32'h0, {31'h0, rd[4]});
		repeat (400) @(posedge clk_sys);
		apb(1'b0, uart_pkg::ADDR_STAT, 32'h0);
		chk("framing_error stat", 32'hb115, rd);
		end_sim;
	end
endmodule : tb_top
